// ===== design/ocfr_core.sv
/*
  fault reaction logic for one channel's overcurrent and undercurrent.
  assumes fast comparator levels synchronous to ref_clk, setting writes
  as one-cycle strobes from the command engine, and an on command level.
*/
// Notes on behaviour
// - deglitch the fast overcurrent and undercurrent detections before acting
// - a recorded fault sets current status, summary byte and word bits
// - a recorded fault pulls the alert line low
// - action 00b or 01b keeps the channel running, no clamping
// - action 10b runs for the deglitch time, then shuts down, or after turn-off delay when tracking
// - action 11b also runs for the deglitch time, then shuts down, or after turn-off delay when tracking
// - after a fault shutdown the restart field and restart limit decide restarting
// - restart field zero means stay off until an off-then-on sequence
// - nonzero restart field retries up to the global restart limit
// - an off command or another fault abandons pending restarts
// - restart field changes apply from the next off-then-on sequence
// - delay field sets how long a new fault is ignored
// - delay field 000b adds no deglitch delay
// - delay codes map to 100us up to 100ms intervals
// - restarts are spaced by the retry interval in milliseconds
// - clear faults resets status and alert, channel stays off
`timescale 1ns/1ps
`default_nettype none
`include "ocfr_defs.svh"
module ocfr_core
  import ocfr_pkg::*;
#(
  parameter int CYC_PER_US = `OCFR_NS_PER_US / `OCFR_CLK_NS,
  parameter int MS_CYCLES = CYC_PER_US * `OCFR_US_PER_MS,
  parameter int DG_W = 24
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_b, // synchronous reset
  input wire logic oc_detect, // fast overcurrent comparator
  input wire logic uc_detect, // fast undercurrent comparator
  input wire logic oc_reaction_wr, // write overcurrent setting
  input wire logic uc_reaction_wr, // write undercurrent setting
  input wire logic [7:0] reaction_wdata, // setting write data
  input wire logic [2:0] restart_limit, // global restart count
  input wire logic [15:0] retry_interval_ms, // retry spacing
  input wire logic [15:0] turn_off_delay, // sequence-off delay, ms
  input wire logic tracking_en, // sequence off on fault
  input wire logic channel_on_cmd, // control pin and operation
  input wire logic other_fault_off, // another fault shut down
  input wire logic clear_faults, // clear status pulse
  output logic [7:0] overcurrent_fault_reaction, // setting readback
  output logic [7:0] undercurrent_fault_reaction, // setting readback
  output logic [7:0] output_current_status, // current status
  output logic [7:0] status_summary_byte, // summary byte bits
  output logic [15:0] status_summary_word, // summary word bits
  output logic host_alert_n, // alert, low active
  output logic channel_enable // channel run
);

  // deglitch limit in cycles for a delay code
  function automatic logic [DG_W-1:0] dg_limit(input logic [2:0] code);
    int us;
    us = 0;
    unique case (code)
      3'h1: us = `OCFR_DG_US_1;
      3'h2: us = `OCFR_DG_US_2;
      3'h3: us = `OCFR_DG_US_3;
      3'h4: us = `OCFR_DG_US_4;
      3'h5: us = `OCFR_DG_US_5;
      3'h6: us = `OCFR_DG_US_6;
      3'h7: us = `OCFR_DG_US_7;
      3'h0: us = 0;
    endcase
    return DG_W'(us * CYC_PER_US);
  endfunction : dg_limit

  // settings
  logic [7:0] react_reg [2];
  logic [7:0] react_next [2];
  logic [1:0] wr;
  logic [1:0] det;
  assign wr = {uc_reaction_wr, oc_reaction_wr};
  assign det = {uc_detect, oc_detect};

  // setting write path
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      react_next[i] = wr[i] ? reaction_wdata : react_reg[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      react_reg[i] <= !rst_b ? `OCFR_REACT_RST : react_next[i];
    end
  end

  // deglitch timers and qualified faults, one per condition
  logic [DG_W-1:0] dg_reg [2];
  logic [DG_W-1:0] dg_next [2];
  logic [1:0] qual;
  logic [1:0] qual_reg;
  logic [1:0] rise;
  logic [1:0] trip;
  logic [1:0] act_hi;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!det[i]) begin
        dg_next[i] = '0;
      end else if (dg_reg[i] < dg_limit(react_reg[i][`OCFR_DLY_HI:`OCFR_DLY_LO])) begin
        dg_next[i] = dg_reg[i] + DG_W'(1);
      end else begin
        dg_next[i] = dg_reg[i];
      end
      qual[i] = det[i] && (dg_reg[i] >= dg_limit(react_reg[i][`OCFR_DLY_HI:`OCFR_DLY_LO]));
      act_hi[i] = react_reg[i][`OCFR_ACT_HI];
      trip[i] = qual[i] && act_hi[i];
    end
  end
  assign rise = qual & ~qual_reg;

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      dg_reg[i] <= !rst_b ? '0 : dg_next[i];
    end
    qual_reg <= !rst_b ? 2'h0 : qual;
  end

  // status bits and alert; a new fault wins over clear
  logic [7:0] ios_reg, ios_next;
  logic [7:0] sb_reg, sb_next;
  logic [15:0] sw_reg, sw_next;
  logic alert_n_reg, alert_n_next;

  always_comb begin
    ios_next = clear_faults ? 8'h00 : ios_reg;
    sb_next = clear_faults ? 8'h00 : sb_reg;
    sw_next = clear_faults ? 16'h0000 : sw_reg;
    if (rise[OCFR_OC]) begin
      ios_next[`OCFR_IOUT_OC_BIT] = 1'b1;
      sb_next[`OCFR_SB_OC_BIT] = 1'b1;
      sw_next[`OCFR_SW_IOUT_BIT] = 1'b1;
    end
    if (rise[OCFR_UC]) begin
      ios_next[`OCFR_IOUT_UC_BIT] = 1'b1;
      sb_next[`OCFR_SB_OTHER_BIT] = 1'b1;
      sw_next[`OCFR_SW_IOUT_BIT] = 1'b1;
    end
    alert_n_next = ~(|ios_next);
  end

  always_ff @(posedge ref_clk) begin
    ios_reg <= !rst_b ? 8'h00 : ios_next;
    sb_reg <= !rst_b ? 8'h00 : sb_next;
    sw_reg <= !rst_b ? 16'h0000 : sw_next;
    alert_n_reg <= !rst_b ? 1'b1 : alert_n_next;
  end

  // millisecond tick for turn-off delay and retry spacing
  logic [31:0] pre_reg, pre_next;
  logic ms_tick;
  assign ms_tick = (pre_reg == 32'(MS_CYCLES - 1));
  always_comb begin
    pre_next = ms_tick ? 32'h0 : pre_reg + 32'h1;
  end
  always_ff @(posedge ref_clk) begin
    pre_reg <= !rst_b ? 32'h0 : pre_next;
  end

  // channel state machine
  ocfr_state_t st_reg, st_next;
  logic [1:0] pol_reg, pol_next;
  logic [2:0] left_reg, left_next;
  logic [15:0] wait_reg, wait_next;
  logic cause_reg, cause_next;
  logic en_reg, en_next;
  logic wait_done;

  always_comb begin
    st_next = st_reg;
    pol_next = pol_reg;
    left_next = left_reg;
    cause_next = cause_reg;
    wait_next = ms_tick ? wait_reg + 16'h1 : wait_reg;
    wait_done = 1'b0;
    unique case (st_reg)
      OCFR_OFF: begin
        wait_next = 16'h0;
        if (channel_on_cmd) begin
          pol_next[0] = |react_reg[0][`OCFR_RTY_HI:`OCFR_RTY_LO];
          pol_next[1] = |react_reg[1][`OCFR_RTY_HI:`OCFR_RTY_LO];
          left_next = restart_limit;
          st_next = OCFR_ON;
        end
      end
      OCFR_ON: begin
        wait_next = 16'h0;
        if (other_fault_off) begin
          left_next = 3'h0;
          st_next = OCFR_FAULTED;
        end else if (|trip) begin
          cause_next = !trip[OCFR_OC];
          st_next = tracking_en ? OCFR_TOFF : OCFR_FAULTED;
        end
      end
      OCFR_TOFF: begin
        wait_done = (wait_reg >= turn_off_delay);
        if (other_fault_off) begin
          left_next = 3'h0;
          st_next = OCFR_FAULTED;
        end else if (wait_done) begin
          wait_next = 16'h0;
          st_next = OCFR_FAULTED;
        end
      end
      OCFR_FAULTED: begin
        wait_next = 16'h0;
        if (other_fault_off) begin
          left_next = 3'h0;
        end else if (pol_reg[cause_reg] && left_reg != 3'h0) begin
          st_next = OCFR_RETRY;
        end
      end
      OCFR_RETRY: begin
        wait_done = (wait_reg >= retry_interval_ms);
        if (other_fault_off) begin
          left_next = 3'h0;
          st_next = OCFR_FAULTED;
        end else if (wait_done) begin
          left_next = left_reg - 3'h1;
          st_next = OCFR_ON;
        end
      end
      default: st_next = OCFR_OFF;
    endcase
    if (!channel_on_cmd) begin
      st_next = OCFR_OFF;
      left_next = 3'h0;
    end
    en_next = (st_next == OCFR_ON) || (st_next == OCFR_TOFF);
  end

  always_ff @(posedge ref_clk) begin
    st_reg <= !rst_b ? OCFR_OFF : st_next;
    pol_reg <= !rst_b ? 2'h0 : pol_next;
    left_reg <= !rst_b ? 3'h0 : left_next;
    wait_reg <= !rst_b ? 16'h0 : wait_next;
    cause_reg <= !rst_b ? 1'b0 : cause_next;
    en_reg <= !rst_b ? 1'b0 : en_next;
  end

  // outputs straight from flops
  assign overcurrent_fault_reaction = react_reg[OCFR_OC];
  assign undercurrent_fault_reaction = react_reg[OCFR_UC];
  assign output_current_status = ios_reg;
  assign status_summary_byte = sb_reg;
  assign status_summary_word = sw_reg;
  assign host_alert_n = alert_n_reg;
  assign channel_enable = en_reg;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence oc_recorded_s;
    rise[OCFR_OC] && !clear_faults;
  endsequence
  sequence oc_flags_s;
    output_current_status[`OCFR_IOUT_OC_BIT] && status_summary_word[`OCFR_SW_IOUT_BIT];
  endsequence
  sequence retry_wait_s;
    st_reg == OCFR_RETRY && channel_on_cmd && !other_fault_off && wait_done;
  endsequence

  status_bits_set_a: assert property (oc_recorded_s |=> oc_flags_s)
    else $error("overcurrent status bits not set");
  alert_on_fault_a: assert property (|rise |=> !host_alert_n
      ##1 (!host_alert_n || $past(clear_faults)))
    else $error("alert not pulled low on fault");
  keep_running_a: assert property (st_reg == OCFR_ON && !(|act_hi) && channel_on_cmd
      && !other_fault_off |=> st_reg == OCFR_ON && channel_enable)
    else $error("channel stopped with run-through action");
  trip_stop_a: assert property (st_reg == OCFR_ON && |trip && !tracking_en && channel_on_cmd
      && !other_fault_off |=> !channel_enable && st_reg == OCFR_FAULTED)
    else $error("trip did not stop channel at once");
  trip_track_a: assert property (st_reg == OCFR_ON && |trip && tracking_en && channel_on_cmd
      && !other_fault_off |=> st_reg == OCFR_TOFF && channel_enable)
    else $error("tracking trip did not sequence off");
  no_restart_a: assert property (st_reg == OCFR_FAULTED && !pol_reg[cause_reg]
      |=> st_reg != OCFR_RETRY && !channel_enable)
    else $error("restart without restart field");
  retry_count_a: assert property (retry_wait_s |=> st_reg == OCFR_ON
      && left_reg == $past(left_reg) - 3'h1)
    else $error("restart count not consumed");
  off_abandon_a: assert property (!channel_on_cmd |=> st_reg == OCFR_OFF
      && left_reg == 3'h0 && !channel_enable)
    else $error("off command did not abandon restarts");
  clear_keeps_a: assert property (clear_faults && !(|rise) && st_reg == OCFR_FAULTED
      && left_reg == 3'h0 && channel_on_cmd |=> host_alert_n && !channel_enable)
    else $error("clear faults released channel");
  glitch_reset_a: assert property (!det[OCFR_OC] |=> dg_reg[OCFR_OC] == '0)
    else $error("deglitch timer not restarted");
  zero_delay_a: assert property (det[OCFR_UC] && !qual_reg[OCFR_UC]
      && react_reg[OCFR_UC][`OCFR_DLY_HI:`OCFR_DLY_LO] == 3'h0
      |=> output_current_status[`OCFR_IOUT_UC_BIT])
    else $error("zero deglitch code delayed fault");
endmodule : ocfr_core
`default_nettype wire

// ===== design/ocfr_defs.svh
/*
  constants for the output current fault reaction block.
  assumes a 10 ns system clock; included by the design files only.
*/
`ifndef OCFR_DEFS_SVH
`define OCFR_DEFS_SVH
`define OCFR_CLK_NS 10
`define OCFR_NS_PER_US 1000
`define OCFR_US_PER_MS 1000
// field layout of a response setting
`define OCFR_ACT_HI 7
`define OCFR_ACT_LO 6
`define OCFR_RTY_HI 5
`define OCFR_RTY_LO 3
`define OCFR_DLY_HI 2
`define OCFR_DLY_LO 0
`define OCFR_REACT_RST 8'h80
// action codes
`define OCFR_ACT_RUN0 2'h0
`define OCFR_ACT_RUN1 2'h1
`define OCFR_ACT_DLY 2'h2
`define OCFR_ACT_NOW 2'h3
// deglitch intervals in microseconds
`define OCFR_DG_US_1 100
`define OCFR_DG_US_2 1000
`define OCFR_DG_US_3 5000
`define OCFR_DG_US_4 10000
`define OCFR_DG_US_5 20000
`define OCFR_DG_US_6 50000
`define OCFR_DG_US_7 100000
// status bit positions
`define OCFR_IOUT_OC_BIT 7
`define OCFR_IOUT_UC_BIT 4
`define OCFR_SB_OC_BIT 4
`define OCFR_SB_OTHER_BIT 0
`define OCFR_SW_IOUT_BIT 14
`endif

// ===== design/ocfr_pkg.sv
/*
  types of the output current fault reaction block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package ocfr_pkg;
  // channel states, gray along off-on-delay-faulted-retry
  typedef enum logic [2:0] {
    OCFR_OFF = 3'h0,
    OCFR_ON = 3'h1,
    OCFR_TOFF = 3'h3,
    OCFR_FAULTED = 3'h2,
    OCFR_RETRY = 3'h6
  } ocfr_state_t;
  // index of the two watched conditions
  typedef enum logic {
    OCFR_OC = 1'b0,
    OCFR_UC = 1'b1
  } ocfr_cond_t;
endpackage : ocfr_pkg

// ===== testbench/ocfr_supply.sv
/*
  supply channel model facing the fault reaction block.
  assumes the bench sets load levels and shares ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ocfr_supply (
  input wire logic ref_clk, // system clock
  input wire logic channel_enable, // channel run
  input wire logic load_hi, // overload request
  input wire logic load_lo, // underload request
  output logic oc_detect, // overcurrent level
  output logic uc_detect // undercurrent level
);
  // comparators only see current while the channel runs
  always_ff @(posedge ref_clk) begin
    oc_detect <= channel_enable & load_hi;
    uc_detect <= channel_enable & load_lo;
  end
endmodule : ocfr_supply
`default_nettype wire

// ===== testbench/ocfr_tb.sv
/*
  self-checking bench for the fault reaction block.
  assumes short counts: 1 cycle per us, 10 cycles per ms.
*/
`timescale 1ns/1ps
`default_nettype none
module ocfr_tb;
  typedef struct {logic oc; logic [7:0] set; logic [7:0] st; logic [7:0] sb; logic en;} ocfr_row_t;
  logic ref_clk = 1'b0, rst_b = 1'b0, oc_wr = 1'b0, uc_wr = 1'b0, trk = 1'b0;
  logic load_hi = 1'b0, load_lo = 1'b0, on_cmd = 1'b0, other_off = 1'b0, clr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [2:0] limit = 3'h0;
  logic [15:0] retry_ms = 16'h0002, toff = 16'h0003, sw;
  logic oc_det, uc_det, alert_n, ch_en;
  logic [7:0] oc_rb, uc_rb, st, sb;
  int bad_count = 0, checked = 0, rises;
  ocfr_row_t rows [6] = '{'{1, 8'h00, 8'h80, 8'h10, 1}, '{1, 8'h40, 8'h80, 8'h10, 1},
    '{0, 8'h00, 8'h10, 8'h01, 1}, '{0, 8'h40, 8'h10, 8'h01, 1},
    '{1, 8'hc0, 8'h80, 8'h10, 0}, '{0, 8'h80, 8'h10, 8'h01, 0}};

  // free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  ocfr_core #(.CYC_PER_US(1), .MS_CYCLES(10)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .oc_detect(oc_det), .uc_detect(uc_det), .oc_reaction_wr(oc_wr), .uc_reaction_wr(uc_wr),
    .reaction_wdata(wdata), .restart_limit(limit), .retry_interval_ms(retry_ms),
    .turn_off_delay(toff), .tracking_en(trk), .channel_on_cmd(on_cmd),
    .other_fault_off(other_off), .clear_faults(clr), .overcurrent_fault_reaction(oc_rb),
    .undercurrent_fault_reaction(uc_rb), .output_current_status(st),
    .status_summary_byte(sb), .status_summary_word(sw), .host_alert_n(alert_n),
    .channel_enable(ch_en));

  ocfr_supply far_end (.ref_clk(ref_clk), .channel_enable(ch_en), .load_hi(load_hi),
    .load_lo(load_lo), .oc_detect(oc_det), .uc_detect(uc_det));

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic oc, input logic [7:0] d);
    oc_wr = oc;
    uc_wr = !oc;
    wdata = d;
    tick(1);
    oc_wr = 1'b0;
    uc_wr = 1'b0;
  endtask : wr

  // drop loads, clear status and turn the channel off
  task clean;
    load_hi = 1'b0;
    load_lo = 1'b0;
    tick(2);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    on_cmd = 1'b0;
    tick(3);
  endtask : clean

  task start(input logic [7:0] d);
    wr(1'b1, d);
    on_cmd = 1'b1;
    tick(3);
  endtask : start

  // count restarts after a hard trip; setting rewritten while on
  task retry_run(input logic [2:0] lim, input logic abandon, output int n);
    logic prev;
    limit = lim;
    start(8'hc8);
    wr(1'b1, 8'hc0);
    load_hi = 1'b1;
    tick(5);
    if (abandon) begin
      other_off = 1'b1;
      tick(1);
      other_off = 1'b0;
    end
    n = 0;
    repeat (300) begin
      prev = ch_en;
      tick(1);
      if (ch_en && !prev) n++;
    end
    clean();
  endtask : retry_run

  task print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("watchdog expired");
    print_verdict();
  end

  // main sequence
  initial begin
    tick(12);
    rst_b = 1'b1;
    chk({oc_rb, uc_rb}, 16'h8080);
    chk({st, sb}, 16'h0000);
    chk({alert_n, ch_en}, 16'h0002);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].oc, rows[i].set);
      chk(rows[i].oc ? oc_rb : uc_rb, rows[i].set);
      on_cmd = 1'b1;
      tick(3);
      load_hi = rows[i].oc;
      load_lo = !rows[i].oc;
      tick(5);
      chk({st, sb}, {rows[i].st, rows[i].sb});
      chk(sw, 16'h4000);
      chk(alert_n, 1'b0);
      chk(ch_en, rows[i].en);
      load_hi = 1'b0;
      load_lo = 1'b0;
      tick(2);
      clr = 1'b1;
      tick(2);
      clr = 1'b0;
      chk({st, 7'h00, alert_n}, 16'h0001);
      chk(ch_en, rows[i].en);
      chk(sw, 16'h0000);
      chk({8'h00, sb}, 16'h0000);
      on_cmd = 1'b0;
      tick(3);
    end
    $display("test table done");
    start(8'h01);
    load_hi = 1'b1;
    tick(60);
    load_hi = 1'b0;
    tick(2);
    load_hi = 1'b1;
    tick(90);
    chk(st, 8'h00);
    tick(20);
    chk(st, 8'h80);
    clean();
    $display("test deglitch done");
    start(8'h82);
    load_hi = 1'b1;
    tick(950);
    chk(ch_en, 1'b1);
    tick(100);
    chk(ch_en, 1'b0);
    clean();
    $display("test delayed shutdown done");
    trk = 1'b1;
    start(8'hc0);
    load_hi = 1'b1;
    tick(15);
    chk(ch_en, 1'b1);
    tick(30);
    chk(ch_en, 1'b0);
    trk = 1'b0;
    clean();
    $display("test tracking done");
    retry_run(3'h2, 1'b0, rises);
    chk(16'(rises), 16'h0002);
    retry_run(3'h7, 1'b1, rises);
    chk(16'(rises), 16'h0000);
    $display("test restart done");
    print_verdict();
  end
endmodule : ocfr_tb
`default_nettype wire
